// [src/nsf_framer.sv]
// nsf_framer: builds navigation sentences and sends them on a 4800 8N1 serial line.
// assumes the user feeds field characters through the fifo before or after a start pulse,
// one word per character, a separator word per comma and an end word per sentence.
`timescale 1ns/10ps
module nsf_framer #(
	parameter int BIT_CYC = nsf_pkg::BIT_CYC,
	parameter int SEC_CYC = nsf_pkg::SEC_CYC
) (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       start,
	input  wire logic [2:0] msg_sel,
	input  wire logic [7:0] mode_ind,
	input  wire logic       in_valid,
	input  wire logic [2:0] in_kind,
	input  wire logic [7:0] in_char,
	output logic            in_ready,
	output logic            txd,
	output logic            busy,
	output logic            err_len,
	output logic            err_msg,
	output logic            sec_tick
);
	localparam int DW = $clog2(BIT_CYC + 1);
	localparam int SW = $clog2(SEC_CYC + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(BIT_CYC - 1);
	localparam logic [SW-1:0] SEC_LAST = SW'(SEC_CYC - 1);
	localparam logic [3:0]    BIT_LAST = 4'(nsf_pkg::FRAME_BITS - 1);
	localparam logic [6:0]    BODY_LIM = 7'(nsf_pkg::MAX_BODY - nsf_pkg::CS_LEN);
	localparam logic [6:0]    DATA_LIM = 7'(nsf_pkg::MAX_DATA);
	localparam logic [6:0]    MODE_RES = 7'(nsf_pkg::MODE_LEN);

	typedef enum logic [3:0] {ST_IDLE, ST_HDR, ST_BODY, ST_MODE, ST_STAR, ST_CSH, ST_CSL, ST_CR, ST_LF} nsf_state_t;
	typedef struct packed {
		nsf_state_t        st;
		logic [2:0]        idx;
		nsf_pkg::nsf_msg_t msg;
		logic [7:0]        mode;
		logic [7:0]        csum;
		logic [6:0]        bcnt;
		logic [6:0]        dcnt;
		logic [8:0]        sh;
		logic [3:0]        bitn;
		logic [DW-1:0]     div;
		logic              txbusy;
		logic              txd;
		logic [SW-1:0]     scnt;
		logic              tick;
		logic              busy;
		logic              err_len;
		logic              err_msg;
	} nsf_framer_st_t;

	nsf_framer_st_t s_ff, nxt_s;
	logic           f_valid;
	logic [10:0]    f_data;
	logic           pop;
	logic           load;
	logic [7:0]     ch;
	logic [6:0]     res;
	logic [23:0]    mid;

	nsf_fifo #(
		.WIDTH (nsf_pkg::WORD_W),
		.DEPTH (nsf_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.in_valid  (in_valid),
		.in_data   ({in_kind, in_char}),
		.in_ready  (in_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (pop)
	);

	function automatic logic [23:0] msg_id(input nsf_pkg::nsf_msg_t m);
		case (m)
			nsf_pkg::MSG_GGA: msg_id = nsf_pkg::ID_GGA;
			nsf_pkg::MSG_GLL: msg_id = nsf_pkg::ID_GLL;
			nsf_pkg::MSG_GSA: msg_id = nsf_pkg::ID_GSA;
			nsf_pkg::MSG_GSV: msg_id = nsf_pkg::ID_GSV;
			nsf_pkg::MSG_RMC: msg_id = nsf_pkg::ID_RMC;
			nsf_pkg::MSG_VTG: msg_id = nsf_pkg::ID_VTG;
			default:          msg_id = nsf_pkg::ID_ZDA;
		endcase
	endfunction

	function automatic logic has_mode(input nsf_pkg::nsf_msg_t m);
		has_mode = (m == nsf_pkg::MSG_GLL) || (m == nsf_pkg::MSG_RMC) || (m == nsf_pkg::MSG_VTG);
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < nsf_pkg::HEX_TEN) ? nsf_pkg::ASC_ZERO + {4'h0, n} : nsf_pkg::ASC_HEXOFS + {4'h0, n};
	endfunction

	// non-digits in a fixed numeric field become zero so the field width is kept
	function automatic logic [7:0] fmt_char(input logic [2:0] k, input logic [7:0] c);
		case (k)
			nsf_pkg::KND_DIGIT:  fmt_char = (c[3:0] > nsf_pkg::DIGIT_MAX) ? nsf_pkg::ASC_ZERO
			                                : nsf_pkg::ASC_ZERO + {4'h0, c[3:0]};
			nsf_pkg::KND_STATUS: fmt_char = c[0] ? nsf_pkg::ASC_A : nsf_pkg::ASC_V;
			nsf_pkg::KND_POINT:  fmt_char = nsf_pkg::ASC_DOT;
			nsf_pkg::KND_SEP:    fmt_char = nsf_pkg::ASC_COMMA;
			default:             fmt_char = c;
		endcase
	endfunction

	always_comb begin
		nxt_s = s_ff;
		pop = 1'b0;
		load = 1'b0;
		ch = '0;
		res = has_mode(s_ff.msg) ? MODE_RES : '0;
		// the identifier is held in a variable so that its bytes can be selected
		mid = msg_id(s_ff.msg);
		// report pacing
		nxt_s.tick = 1'b0;
		if (s_ff.scnt == SEC_LAST) begin
			nxt_s.scnt = '0;
			nxt_s.tick = 1'b1;
		end else begin
			nxt_s.scnt = s_ff.scnt + 1'b1;
		end
		// serial shifter, one bit per BIT_CYC cycles
		if (s_ff.txbusy) begin
			if (s_ff.div == DIV_LAST) begin
				nxt_s.div = '0;
				if (s_ff.bitn == BIT_LAST) begin
					nxt_s.txbusy = 1'b0;
				end else begin
					nxt_s.txd = s_ff.sh[0];
					nxt_s.sh = {1'b1, s_ff.sh[8:1]};
					nxt_s.bitn = s_ff.bitn + 1'b1;
				end
			end else begin
				nxt_s.div = s_ff.div + 1'b1;
			end
		end
		case (s_ff.st)
			ST_IDLE: begin
				if (start) begin
					if (msg_sel <= nsf_pkg::MSG_ZDA) begin
						nxt_s.st = ST_HDR;
						nxt_s.idx = '0;
						nxt_s.msg = nsf_pkg::nsf_msg_t'(msg_sel);
						nxt_s.mode = mode_ind;
						nxt_s.csum = '0;
						nxt_s.bcnt = '0;
						nxt_s.dcnt = '0;
						nxt_s.busy = 1'b1;
						nxt_s.err_len = 1'b0;
						nxt_s.err_msg = 1'b0;
					end else begin
						nxt_s.err_msg = 1'b1;
					end
				end
			end
			ST_HDR: begin
				if (!s_ff.txbusy) begin
					load = 1'b1;
					case (s_ff.idx)
						3'h0:    ch = nsf_pkg::ASC_DOLLAR;
						3'h1:    ch = nsf_pkg::ASC_G;
						3'h2:    ch = nsf_pkg::ASC_P;
						3'h3:    ch = mid[23:16];
						3'h4:    ch = mid[15:8];
						default: ch = mid[7:0];
					endcase
					if (s_ff.idx != '0) begin
						nxt_s.csum = s_ff.csum ^ ch;
						nxt_s.bcnt = s_ff.bcnt + 1'b1;
					end
					if (s_ff.idx == nsf_pkg::HDR_LAST)
						nxt_s.st = ST_BODY;
					else
						nxt_s.idx = s_ff.idx + 1'b1;
				end
			end
			ST_BODY: begin
				// a word is popped only when the shifter is free, so the fifo backs up
				if (!s_ff.txbusy && f_valid) begin
					pop = 1'b1;
					if (f_data[10:8] == nsf_pkg::KND_END) begin
						nxt_s.idx = '0;
						nxt_s.st = has_mode(s_ff.msg) ? ST_MODE : ST_STAR;
					end else if ((s_ff.dcnt + res < DATA_LIM) && (s_ff.bcnt + res < BODY_LIM)) begin
						load = 1'b1;
						ch = fmt_char(f_data[10:8], f_data[7:0]);
						nxt_s.csum = s_ff.csum ^ ch;
						nxt_s.bcnt = s_ff.bcnt + 1'b1;
						nxt_s.dcnt = s_ff.dcnt + 1'b1;
					end else begin
						// overlong content is dropped rather than breaking the frame
						nxt_s.err_len = 1'b1;
					end
				end
			end
			ST_MODE: begin
				if (!s_ff.txbusy) begin
					load = 1'b1;
					ch = (s_ff.idx == '0) ? nsf_pkg::ASC_COMMA : s_ff.mode;
					nxt_s.csum = s_ff.csum ^ ch;
					nxt_s.bcnt = s_ff.bcnt + 1'b1;
					nxt_s.dcnt = s_ff.dcnt + 1'b1;
					if (s_ff.idx != '0)
						nxt_s.st = ST_STAR;
					else
						nxt_s.idx = s_ff.idx + 1'b1;
				end
			end
			ST_STAR: begin
				if (!s_ff.txbusy) begin
					load = 1'b1;
					ch = nsf_pkg::ASC_STAR;
					nxt_s.st = ST_CSH;
				end
			end
			ST_CSH: begin
				if (!s_ff.txbusy) begin
					load = 1'b1;
					ch = hex_char(s_ff.csum[7:4]);
					nxt_s.st = ST_CSL;
				end
			end
			ST_CSL: begin
				if (!s_ff.txbusy) begin
					load = 1'b1;
					ch = hex_char(s_ff.csum[3:0]);
					nxt_s.st = ST_CR;
				end
			end
			ST_CR: begin
				if (!s_ff.txbusy) begin
					load = 1'b1;
					ch = nsf_pkg::ASC_CR;
					nxt_s.st = ST_LF;
				end
			end
			ST_LF: begin
				if (!s_ff.txbusy) begin
					load = 1'b1;
					ch = nsf_pkg::ASC_LF;
					nxt_s.st = ST_IDLE;
					nxt_s.busy = 1'b0;
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase
		if (load) begin
			nxt_s.txd = 1'b0;
			nxt_s.sh = {1'b1, ch};
			nxt_s.bitn = '0;
			nxt_s.div = '0;
			nxt_s.txbusy = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_ff <= '0;
			s_ff.st <= ST_IDLE;
			s_ff.txd <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign txd = s_ff.txd;
	assign busy = s_ff.busy;
	assign err_len = s_ff.err_len;
	assign err_msg = s_ff.err_msg;
	assign sec_tick = s_ff.tick;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_line_idle: assert property (!s_ff.txbusy |-> s_ff.txd)
		else $error("line not idle high between characters");
	a_bit_time: assert property ($changed(s_ff.txd) |-> $past(load) || $past(s_ff.div) == DIV_LAST)
		else $error("serial bit changed off the baud boundary");
	a_start_dollar: assert property (load && s_ff.st == ST_HDR && s_ff.idx == '0 |-> ch == nsf_pkg::ASC_DOLLAR)
		else $error("sentence did not open with dollar");
	a_talker_gp: assert property (load && s_ff.st == ST_HDR && (s_ff.idx == 3'h1 || s_ff.idx == 3'h2) |-> ch == ((s_ff.idx == 3'h1) ? nsf_pkg::ASC_G : nsf_pkg::ASC_P))
		else $error("talker identifier wrong");
	a_cs_digit: assert property (load && s_ff.st == ST_CSH |-> ch == hex_char(s_ff.csum[7:4]) ##1 s_ff.st == ST_CSL)
		else $error("checksum high digit wrong");
	a_cr_then_lf: assert property (load && s_ff.st == ST_CR |=> s_ff.st == ST_LF && s_ff.txbusy)
		else $error("carriage return not followed by line feed");
	a_body_len: assert property (s_ff.bcnt <= BODY_LIM && s_ff.dcnt <= DATA_LIM)
		else $error("sentence length limit exceeded");
	a_no_space: assert property (load && ch == nsf_pkg::ASC_SPACE |-> s_ff.st == ST_BODY && f_data[10:8] == nsf_pkg::KND_TEXT)
		else $error("space outside a text field");
	a_msg_set: assert property (s_ff.busy |-> s_ff.msg <= nsf_pkg::MSG_ZDA)
		else $error("unsupported sentence type in progress");
	a_mode_field: assert property (s_ff.st == ST_MODE ##1 s_ff.st == ST_STAR |-> has_mode(s_ff.msg))
		else $error("mode field on a sentence without one");
	a_no_overlap: assert property (start && s_ff.busy |=> s_ff.st != ST_HDR || $past(s_ff.st) == ST_HDR)
		else $error("new sentence interleaved with running one");
endmodule // nsf_framer

// [common/nsf_pkg.sv]
// nsf_pkg: constants, character codes and enumerations of the sentence framer.
// assumes one 200 MHz clock; all users refer to names as nsf_pkg::name.
package nsf_pkg;
	localparam int CLK_HZ       = 200_000_000;
	localparam int BAUD_RATE    = 4800;
	localparam int REPORT_SEC   = 1;
	localparam int BIT_CYC      = CLK_HZ / BAUD_RATE;
	localparam int SEC_CYC      = CLK_HZ * REPORT_SEC;
	localparam int DATA_BITS    = 8;
	localparam int FRAME_BITS   = DATA_BITS + 2;
	localparam int MAX_BODY     = 79;
	localparam int MAX_DATA     = 74;
	localparam int CS_LEN       = 3;
	localparam int MODE_LEN     = 2;
	localparam int FIFO_DEPTH   = 4;
	localparam logic [2:0] HDR_LAST   = 3'h5;
	localparam logic [3:0] DIGIT_MAX  = 4'h9;
	localparam logic [3:0] HEX_TEN    = 4'hA;
	localparam logic [7:0] ASC_DOLLAR = 8'h24;
	localparam logic [7:0] ASC_COMMA  = 8'h2C;
	localparam logic [7:0] ASC_STAR   = 8'h2A;
	localparam logic [7:0] ASC_DOT    = 8'h2E;
	localparam logic [7:0] ASC_CR     = 8'h0D;
	localparam logic [7:0] ASC_LF     = 8'h0A;
	localparam logic [7:0] ASC_G      = 8'h47;
	localparam logic [7:0] ASC_P      = 8'h50;
	localparam logic [7:0] ASC_A      = 8'h41;
	localparam logic [7:0] ASC_V      = 8'h56;
	localparam logic [7:0] ASC_ZERO   = 8'h30;
	localparam logic [7:0] ASC_SPACE  = 8'h20;
	localparam logic [7:0] ASC_HEXOFS = 8'h37;
	localparam logic [23:0] ID_GGA = 24'h47_4741;
	localparam logic [23:0] ID_GLL = 24'h47_4C4C;
	localparam logic [23:0] ID_GSA = 24'h47_5341;
	localparam logic [23:0] ID_GSV = 24'h47_5356;
	localparam logic [23:0] ID_RMC = 24'h52_4D43;
	localparam logic [23:0] ID_VTG = 24'h56_5447;
	localparam logic [23:0] ID_ZDA = 24'h5A_4441;
	typedef enum logic [2:0] {MSG_GGA, MSG_GLL, MSG_GSA, MSG_GSV, MSG_RMC, MSG_VTG, MSG_ZDA} nsf_msg_t;
	typedef enum logic [2:0] {KND_TEXT, KND_DIGIT, KND_STATUS, KND_POINT, KND_SEP, KND_END} nsf_kind_t;
	localparam int WORD_W = 11;
endpackage

// [src/nsf_fifo.sv]
// nsf_fifo: small synchronous fifo with valid/ready on both sides.
// assumes DEPTH is a power of two; in_ready is registered.
`timescale 1ns/10ps
module nsf_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 4
) (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        rdy;
	} nsf_fifo_st_t;
	nsf_fifo_st_t s_ff, nxt_s;
	logic push, pop;

	always_comb begin
		nxt_s = s_ff;
		push = in_valid && s_ff.rdy;
		pop = out_ready && (s_ff.cnt != '0);
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = s_ff.wp + 1'b1;
		end
		if (pop)
			nxt_s.rp = s_ff.rp + 1'b1;
		nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
		nxt_s.rdy = (nxt_s.cnt != FULL_CNT);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_ff <= '0;
			s_ff.rdy <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign in_ready = s_ff.rdy;
	assign out_valid = (s_ff.cnt != '0);
	assign out_data = s_ff.mem[s_ff.rp];
endmodule // nsf_fifo

// [bench/nsf_listener.sv]
// nsf_listener: behavioural listener on the framer's serial transmit line.
// assumes 8N1 framing at BIT_CYC clocks per bit; it only listens, never drives.
`timescale 1ns/10ps
module nsf_listener #(
	parameter int BIT_CYC = 4
) (
	input wire logic mclk,
	input wire logic txd
);
	logic [7:0] rxq[$];
	int         frame_err;
	logic [7:0] b;
	initial frame_err = 0;
	// no output port at all: the line is one-way
	always begin
		@(negedge txd);
		// sample on the falling clock edge, away from the register update of txd
		repeat (BIT_CYC / 2) @(negedge mclk);
		if (txd !== 1'b0) frame_err++;
		for (int i = 0; i < nsf_pkg::DATA_BITS; i++) begin
			repeat (BIT_CYC) @(negedge mclk);
			b[i] = txd;
		end
		repeat (BIT_CYC) @(negedge mclk);
		if (txd !== 1'b1) frame_err++;
		rxq.push_back(b);
	end
endmodule // nsf_listener

// [bench/tb_top.sv]
// tb_top: self-checking bench of the sentence framer with a serial listener.
// assumes short bit and report counts; inputs change on the falling clock edge.
`timescale 1ns/10ps
module tb_top;
	localparam int BIT = 4;
	localparam int SEC = 50;
	logic       mclk, sys_rst, start, in_valid, in_ready, txd, busy, err_len, err_msg, sec_tick;
	logic [2:0] msg_sel, in_kind;
	logic [7:0] mode_ind, in_char;
	int         errors, cmp_count, cyc;
	logic [2:0] wk[$];
	logic [7:0] wc[$], exp_q[$];

	nsf_framer #(.BIT_CYC(BIT), .SEC_CYC(SEC)) dut (.mclk(mclk), .sys_rst(sys_rst), .start(start),
		.msg_sel(msg_sel), .mode_ind(mode_ind), .in_valid(in_valid), .in_kind(in_kind), .in_char(in_char),
		.in_ready(in_ready), .txd(txd), .busy(busy), .err_len(err_len), .err_msg(err_msg), .sec_tick(sec_tick));
	nsf_listener #(.BIT_CYC(BIT)) lsn (.mclk(mclk), .txd(txd));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic close_out();
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc > 30000) begin
			$display("MISMATCH at %0t: timeout", $time);
			errors++;
			close_out();
		end
	end

	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask

	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'hA) ? nsf_pkg::ASC_ZERO + v : nsf_pkg::ASC_HEXOFS + v;
	endfunction

	task automatic add(input logic [2:0] k, input logic [7:0] c, input logic [7:0] e);
		wk.push_back(k);
		wc.push_back(c);
		if (k != nsf_pkg::KND_END) exp_q.push_back(e);
	endtask

	task automatic digits(input string s);
		for (int i = 0; i < s.len(); i++) add(nsf_pkg::KND_DIGIT, s[i] - 8'h30, s[i]);
	endtask

	task automatic put(input logic [2:0] k, input logic [7:0] c);
		int n;
		@(negedge mclk);
		in_valid = 1'b1;
		in_kind = k;
		in_char = c;
		n = 0;
		while (in_ready !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
	endtask

	// feeds the queued words around a start pulse and compares the whole received sentence
	task automatic send(input logic [2:0] m, input logic [7:0] md);
		logic [7:0] full[$];
		logic [7:0] cs;
		logic [23:0] id;
		int n;
		int nc;
		int ne;
		lsn.rxq.delete();
		n = (wk.size() < 4) ? wk.size() : 4;
		repeat (n) put(wk.pop_front(), wc.pop_front());
		@(negedge mclk);
		in_valid = 1'b0;
		if (n == 4) chk(in_ready === 1'b0, "fifo not full after four words");
		start = 1'b1;
		msg_sel = m;
		mode_ind = md;
		@(negedge mclk);
		start = 1'b0;
		chk(busy === 1'b1 && err_msg === 1'b0 && err_len === 1'b0, "start not taken or flags kept");
		// a refused type offered mid-sentence must be ignored, not flagged
		@(negedge mclk);
		start = 1'b1;
		msg_sel = 3'h7;
		@(negedge mclk);
		start = 1'b0;
		chk(busy === 1'b1 && err_msg === 1'b0, "start while busy not ignored");
		while (wk.size() > 0) put(wk.pop_front(), wc.pop_front());
		@(negedge mclk);
		in_valid = 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		repeat (12 * BIT) @(negedge mclk);
		case (m)
			3'h0: id = nsf_pkg::ID_GGA;
			3'h1: id = nsf_pkg::ID_GLL;
			3'h2: id = nsf_pkg::ID_GSA;
			3'h3: id = nsf_pkg::ID_GSV;
			3'h4: id = nsf_pkg::ID_RMC;
			3'h5: id = nsf_pkg::ID_VTG;
			default: id = nsf_pkg::ID_ZDA;
		endcase
		full = {nsf_pkg::ASC_DOLLAR, nsf_pkg::ASC_G, nsf_pkg::ASC_P, id[23:16], id[15:8], id[7:0]};
		foreach (exp_q[i]) full.push_back(exp_q[i]);
		if (m == 3'h1 || m == 3'h4 || m == 3'h5) full = {full, nsf_pkg::ASC_COMMA, md};
		cs = 8'h00;
		for (int i = 1; i < full.size(); i++) cs ^= full[i];
		full = {full, nsf_pkg::ASC_STAR, hx(cs[7:4]), hx(cs[3:0]), nsf_pkg::ASC_CR, nsf_pkg::ASC_LF};
		chk(lsn.rxq.size() == full.size(), "sentence length");
		for (int i = 0; i < full.size() && i < lsn.rxq.size(); i++)
			chk(lsn.rxq[i] === full[i], "sentence character");
		chk(lsn.frame_err == 0, "serial framing");
		nc = 0;
		ne = 0;
		foreach (lsn.rxq[i]) if (lsn.rxq[i] === nsf_pkg::ASC_COMMA) nc++;
		foreach (full[i]) if (full[i] === nsf_pkg::ASC_COMMA) ne++;
		chk(nc == ne && nc > 0, "field count by commas");
		exp_q.delete();
	endtask

	task automatic s_types();
		for (int m = 0; m < 7; m++) begin
			add(nsf_pkg::KND_SEP, 8'h00, nsf_pkg::ASC_COMMA);
			add(nsf_pkg::KND_STATUS, 8'h01, nsf_pkg::ASC_A);
			add(nsf_pkg::KND_END, 8'h00, 8'h00);
			send(m[2:0], nsf_pkg::ASC_A + m[7:0]);
		end
	endtask

	task automatic s_fields();
		add(nsf_pkg::KND_SEP, 8'h00, nsf_pkg::ASC_COMMA);
		digits("093005");
		add(nsf_pkg::KND_POINT, 8'h00, nsf_pkg::ASC_DOT);
		digits("5");
		add(nsf_pkg::KND_SEP, 8'h00, nsf_pkg::ASC_COMMA);
		digits("0407");
		add(nsf_pkg::KND_DIGIT, 8'h0C, nsf_pkg::ASC_ZERO);
		add(nsf_pkg::KND_SEP, 8'h00, nsf_pkg::ASC_COMMA);
		add(nsf_pkg::KND_STATUS, 8'h00, nsf_pkg::ASC_V);
		add(nsf_pkg::KND_SEP, 8'h00, nsf_pkg::ASC_COMMA);
		add(nsf_pkg::KND_SEP, 8'h00, nsf_pkg::ASC_COMMA);
		add(nsf_pkg::KND_TEXT, nsf_pkg::ASC_SPACE, nsf_pkg::ASC_SPACE);
		add(nsf_pkg::KND_END, 8'h00, 8'h00);
		send(3'h0, 8'h00);
	endtask

	task automatic s_length();
		add(nsf_pkg::KND_SEP, 8'h00, nsf_pkg::ASC_COMMA);
		// talker, id and 71 data characters reach 76, leaving room for star and checksum;
		// the tail is dropped, so it is queued without expectation
		repeat (70) add(nsf_pkg::KND_TEXT, 8'h78, 8'h78);
		repeat (10) begin
			wk.push_back(nsf_pkg::KND_TEXT);
			wc.push_back(8'h78);
		end
		add(nsf_pkg::KND_END, 8'h00, 8'h00);
		send(3'h0, 8'h00);
		chk(err_len === 1'b1, "length error flag");
	endtask

	task automatic s_badmsg();
		lsn.rxq.delete();
		@(negedge mclk);
		start = 1'b1;
		msg_sel = 3'h7;
		@(negedge mclk);
		start = 1'b0;
		chk(err_msg === 1'b1, "bad type not flagged");
		repeat (20 * BIT) @(negedge mclk);
		chk(lsn.rxq.size() == 0 && busy === 1'b0, "bad type emitted");
	endtask

	// reset in the stop bit of a sentence's second character must return the line and flags to idle
	task automatic s_reset();
		@(negedge mclk);
		start = 1'b1;
		msg_sel = 3'h0;
		@(negedge mclk);
		start = 1'b0;
		repeat (20 * BIT) @(negedge mclk);
		sys_rst = 1'b1;
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		chk(txd === 1'b1 && busy === 1'b0 && in_ready === 1'b1 && err_msg === 1'b0 && err_len === 1'b0,
			"mid-run reset state");
		repeat (12 * BIT) @(negedge mclk);
	endtask

	task automatic s_tick();
		int n;
		n = 0;
		while (sec_tick !== 1'b1 && n < 2 * SEC) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		@(negedge mclk);
		while (sec_tick !== 1'b1 && n < 2 * SEC) begin
			@(negedge mclk);
			n++;
		end
		chk(n + 1 == SEC, "report tick period");
	endtask

	initial begin
		errors = 0;
		cmp_count = 0;
		cyc = 0;
		sys_rst = 1'b1;
		{start, in_valid, msg_sel, in_kind, mode_ind, in_char} = '0;
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		chk(txd === 1'b1 && busy === 1'b0 && in_ready === 1'b1, "reset state");
		s_tick();
		s_types();
		s_badmsg();
		s_reset();
		s_fields();
		s_length();
		s_types();
		close_out();
	end
endmodule // tb_top
